// >>> verilog/acsf_top.sv
// Alert status for channels 12 to 15 and clamp status for 0 to 7.
// Assumes conversion results, thresholds, enables and the setup byte
// come from logic on this clock; the clamp levels come from the
// analog front end and are asynchronous to it.
`timescale 1ns/1ps
`include "acsf_defs.svh"
module acsf_top #(
  parameter int DW = 16,
  parameter int AW = 16
) (
  input  wire logic                             clock,
  input  wire logic                             srst,
  input  wire logic                             conv_valid,
  input  wire logic [3:0]                       conv_chan,
  input  wire logic [DW-1:0]                    conv_result,
  input  wire logic [`ACSF_NUM_CH-1:0][DW-1:0]  upper_thr,
  input  wire logic [`ACSF_NUM_CH-1:0][DW-1:0]  lower_thr,
  input  wire logic [`ACSF_NUM_CH-1:0][DW-1:0]  hyst_val,
  input  wire logic [`ACSF_NUM_CH-1:0]          detect_en,
  input  wire logic [7:0]                       setup_byte,
  input  wire logic [7:0]                       clamp_pin,
  input  wire logic                             rd_strobe,
  input  wire logic [AW-1:0]                    rd_addr,
  output logic [7:0]                            rd_data,
  output logic                                  rd_valid,
  output logic [7:0]                            alert_flags_upper_channels,
  output logic [7:0]                            clamp_flags_low_channels
);

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Maps a read address onto the register it selects. Both the read
  // path and the checks below use it, so the map lives in one place.
  function automatic acsf_pkg::acsf_sel_e sel_of(input logic [AW-1:0] a);
    acsf_pkg::acsf_sel_e s;
    s = acsf_pkg::ACSF_SEL_NONE;
    // [R8] register addresses
    if (a == AW'(`ACSF_ALERT_ADDR)) begin
      s = acsf_pkg::ACSF_SEL_ALERT;
    end else if (a == AW'(`ACSF_CLAMP_ADDR)) begin
      s = acsf_pkg::ACSF_SEL_CLAMP;
    end
    return s;
  endfunction

  acsf_pkg::acsf_sel_e rd_sel;       // Register picked by this read.
  logic                alert_rd_clr; // Clearing read of alert flags.

  // Decode of the current read request.
  always_comb begin
    rd_sel       = sel_of(rd_addr);
    // [R4] read clears alerts
    alert_rd_clr = rd_strobe && (rd_sel == acsf_pkg::ACSF_SEL_ALERT);
  end

  // ****************************************************************
  // Alert flags, one instance per channel
  // ****************************************************************
  logic [`ACSF_NUM_CH-1:0] over_flags;   // Upper flags, channel order.
  logic [`ACSF_NUM_CH-1:0] under_flags;  // Lower flags, channel order.
  logic                    alert_mode;   // Hysteresis clearing allowed.

  // [R10] mode from setup bit
  assign alert_mode = setup_byte[`ACSF_MODE_BIT];

  for (genvar i = 0; i < `ACSF_NUM_CH; i++) begin : g_chan
    logic hit;  // A conversion for this channel is presented.

    // Route each conversion only to its own channel.
    assign hit = conv_valid &&
                 (conv_chan == 4'(`ACSF_FIRST_CH + 4'(i)));

    acsf_alert_chan #(
      .DW (DW)
    ) u_chan (
      .clock      (clock),
      .srst       (srst),
      .conv_hit   (hit),
      .result     (conv_result),
      .upper_thr  (upper_thr[i]),
      .lower_thr  (lower_thr[i]),
      .hyst_val   (hyst_val[i]),
      .detect_en  (detect_en[i]),
      .alert_mode (alert_mode),
      .read_clr   (alert_rd_clr),
      .over_flag  (over_flags[i]),
      .under_flag (under_flags[i])
    );

    // [R9] lower above upper
    assign alert_flags_upper_channels[2*i]   = over_flags[i];
    assign alert_flags_upper_channels[2*i+1] = under_flags[i];
  end

  // ****************************************************************
  // Clamp flags
  // ****************************************************************
  logic [7:0] clamp_sync1_reg;  // First synchroniser stage.
  logic [7:0] clamp_sync2_reg;  // Second synchroniser stage.
  logic [7:0] clamp_reg;        // Live clamp state seen by the host.
  logic [7:0] clamp_next;       // Its next value.

  // The clamp bits are levels, not events, so a plain two stage
  // synchroniser is enough. A clamp pulse shorter than a clock period
  // may be missed; the host only ever sees the settled state.
  always_comb begin
    // [R6] [R7] follow clamp level
    clamp_next = clamp_sync2_reg;
  end

  // Synchroniser and output stage.
  always_ff @(posedge clock) begin
    if (srst) begin
      clamp_sync1_reg <= `ACSF_CLAMP_RST;
      clamp_sync2_reg <= `ACSF_CLAMP_RST;
      clamp_reg       <= `ACSF_CLAMP_RST;
    end else begin
      clamp_sync1_reg <= clamp_pin;
      clamp_sync2_reg <= clamp_sync1_reg;
      clamp_reg       <= clamp_next;
    end
  end

  assign clamp_flags_low_channels = clamp_reg;

  // ****************************************************************
  // Read port
  // ****************************************************************
  acsf_pkg::acsf_byte_t rd_data_reg;   // Byte returned to the host.
  acsf_pkg::acsf_byte_t rd_data_next;  // Its next value.
  logic                 rd_valid_reg;  // One cycle read answer strobe.
  logic                 rd_valid_next; // Its next value.

  // Every read is answered one cycle later. The alert byte is the
  // value held before the clear, so each set flag is reported once.
  // An address outside the map answers with zero.
  always_comb begin
    rd_data_next  = rd_data_reg;
    rd_valid_next = rd_strobe;
    if (rd_strobe) begin
      unique case (rd_sel)
        acsf_pkg::ACSF_SEL_ALERT: begin
          // [R4] report before clear
          rd_data_next = alert_flags_upper_channels;
        end
        acsf_pkg::ACSF_SEL_CLAMP: begin
          // [R6] clamp byte
          rd_data_next = clamp_reg;
        end
        default: begin
          // Unmapped addresses read as zero.
          rd_data_next = `ACSF_RDATA_RST;
        end
      endcase
    end
  end

  // Read answer registers.
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_data_reg  <= `ACSF_RDATA_RST;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign rd_data  = rd_data_reg;
  assign rd_valid = rd_valid_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  read_clears_a: assert property ( // [R4]
    alert_rd_clr && !conv_valid |=> alert_flags_upper_channels == 8'h00)
    else $error("alert read did not clear flags");

  read_reports_a: assert property ( // [R8]
    rd_strobe && sel_of(rd_addr) == acsf_pkg::ACSF_SEL_ALERT
    |=> rd_valid && rd_data == $past(alert_flags_upper_channels))
    else $error("alert read returned wrong byte");

  clamp_follows_a: assert property ( // [R7]
    !$past(srst, 1) && !$past(srst, 2) && !$past(srst, 3)
    |-> clamp_flags_low_channels == $past(clamp_pin, 3))
    else $error("clamp byte does not track pins");

  clamp_read_a: assert property ( // [R6]
    rd_strobe && sel_of(rd_addr) == acsf_pkg::ACSF_SEL_CLAMP
    |=> rd_data == $past(clamp_flags_low_channels))
    else $error("clamp read returned wrong byte");

  set_wins_a: assert property ( // [R11]
    alert_rd_clr && conv_valid && conv_chan == `ACSF_FIRST_CH &&
    detect_en[0] && conv_result >= upper_thr[0]
    |=> alert_flags_upper_channels[0])
    else $error("alert lost during clearing read");

  top_chan_a: assert property ( // [R9]
    conv_valid && conv_chan == 4'hf && detect_en[3] &&
    conv_result <= lower_thr[3] |=> alert_flags_upper_channels[7])
    else $error("channel 15 lower flag not in bit 7");

  unmapped_zero_a: assert property ( // [R8]
    rd_strobe && sel_of(rd_addr) == acsf_pkg::ACSF_SEL_NONE
    |=> rd_valid && rd_data == 8'h00)
    else $error("unmapped read not zero");

  valid_pulse_a: assert property ( // [R8]
    !rd_strobe |=> !rd_valid)
    else $error("read answer without request");

  // The answer byte only moves on a read, so a slow host may sample it
  // any time before its next request.
  data_hold_a: assert property ( // [R8]
    !rd_strobe |=> $stable(rd_data))
    else $error("read data moved without a read");

endmodule

// >>> verilog/acsf_defs.svh
// Constants for the alert and clamp status flag block.
// Assumes it is included by bare name from the top module.
//
// Operation
// [R1] Enabled conversion at/above upper threshold sets upper flag.
// [R2] Enabled conversion at/below lower threshold sets lower flag.
// [R3] Flags stay clear while detection is disabled.
// [R4] Reading the alert register clears its set flags.
// [R5] Alert mode one: hysteresis range also clears flag.
// [R6] Clamp register bit x shows clamp x active.
// [R7] Clamp bits never latch, follow clamp state.
// [R8] Alert at 0x0018, clamp at 0x001a, reset zero.
// [R9] Two bits per channel, lower above upper.
// [R10] Alert mode select is setup register bit 7.
// [R11] New alert during clearing read stays set.
`ifndef ACSF_DEFS_SVH
`define ACSF_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define ACSF_ALERT_ADDR 16'h0018
`define ACSF_CLAMP_ADDR 16'h001a
`define ACSF_ALERT_RST  8'h00
`define ACSF_CLAMP_RST  8'h00
`define ACSF_RDATA_RST  8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define ACSF_MODE_BIT   7
`define ACSF_FIRST_CH   4'hc
`define ACSF_NUM_CH     4

`endif

// >>> verilog/acsf_pkg.sv
// Types shared by the alert and clamp status flag block.
// Assumes the constants header sits beside it on the include path.
package acsf_pkg;

  // ****************************************************************
  // Register select decoded from a read address
  // ****************************************************************
  typedef enum logic [1:0] {
    ACSF_SEL_NONE  = 2'b00,
    ACSF_SEL_ALERT = 2'b01,
    ACSF_SEL_CLAMP = 2'b10
  } acsf_sel_e;

  // One register byte as seen by the host.
  typedef logic [7:0] acsf_byte_t;

endpackage

// >>> verilog/acsf_alert_chan.sv
// Upper and lower alert flags of one analog channel.
// Assumes conversion inputs come from logic on the same clock.
`timescale 1ns/1ps
module acsf_alert_chan #(
  parameter int DW = 16
) (
  input  wire logic          clock,
  input  wire logic          srst,
  input  wire logic          conv_hit,
  input  wire logic [DW-1:0] result,
  input  wire logic [DW-1:0] upper_thr,
  input  wire logic [DW-1:0] lower_thr,
  input  wire logic [DW-1:0] hyst_val,
  input  wire logic          detect_en,
  input  wire logic          alert_mode,
  input  wire logic          read_clr,
  output logic               over_flag,
  output logic               under_flag
);

  // ****************************************************************
  // Flag state
  // ****************************************************************
  logic over_reg;    // Upper alert flag.
  logic over_next;   // Its next value.
  logic under_reg;   // Lower alert flag.
  logic under_next;  // Its next value.
  logic over_set;    // Upper threshold crossed this cycle.
  logic under_set;   // Lower threshold crossed this cycle.
  logic over_hclr;   // Result back below upper minus hysteresis.
  logic under_hclr;  // Result back above lower plus hysteresis.

  // Next flag values. The widened sums keep the hysteresis band from
  // wrapping round at either end of the code range.
  always_comb begin
    // [R1] [R3] upper set
    over_set   = conv_hit && detect_en && (result >= upper_thr);
    // [R2] [R3] lower set
    under_set  = conv_hit && detect_en && (result <= lower_thr);
    // [R5] hysteresis clear
    over_hclr  = conv_hit && alert_mode &&
                 ({1'b0, result} + {1'b0, hyst_val} < {1'b0, upper_thr});
    under_hclr = conv_hit && alert_mode &&
                 ({1'b0, result} > {1'b0, lower_thr} + {1'b0, hyst_val});
    if (!detect_en) begin
      // [R3] disabled holds clear
      over_next  = 1'b0;
      under_next = 1'b0;
    end else begin
      // [R4] [R11] set beats clear
      over_next  = over_set  || (over_reg  && !read_clr && !over_hclr);
      under_next = under_set || (under_reg && !read_clr && !under_hclr);
    end
  end

  // Register the flags.
  always_ff @(posedge clock) begin
    if (srst) begin
      over_reg  <= 1'b0;
      under_reg <= 1'b0;
    end else begin
      over_reg  <= over_next;
      under_reg <= under_next;
    end
  end

  assign over_flag  = over_reg;
  assign under_flag = under_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  upper_set_a: assert property ( // [R1]
    conv_hit && detect_en && result >= upper_thr |=> over_reg)
    else $error("upper flag not set by crossing");

  lower_set_a: assert property ( // [R2]
    conv_hit && detect_en && result <= lower_thr |=> under_reg)
    else $error("lower flag not set by crossing");

  disabled_clear_a: assert property ( // [R3]
    !detect_en |=> !over_reg && !under_reg)
    else $error("flag set while detection disabled");

  hyst_clear_a: assert property ( // [R5]
    over_reg && conv_hit && alert_mode && detect_en &&
    result < upper_thr && !read_clr &&
    {1'b0, result} + {1'b0, hyst_val} < {1'b0, upper_thr} |=> !over_reg)
    else $error("hysteresis did not clear upper flag");

  hyst_keep_a: assert property ( // [R10]
    over_reg && !alert_mode && !read_clr && detect_en |=> over_reg)
    else $error("upper flag cleared without read");

endmodule

// >>> tb/acsf_host_model.sv
// Host side model that reads status registers one byte at a time.
// Assumes the block answers on rd_valid a cycle after the strobe.
`timescale 1ns/1ps
module acsf_host_model (
  input  wire logic        clock,
  input  wire logic        rd_valid,
  input  wire logic [7:0]  rd_data,
  output logic             rd_strobe,
  output logic [15:0]      rd_addr
);
  // Bus idle from time zero.
  initial begin
    rd_strobe = 1'b0;
    rd_addr   = 16'hffff;
  end

  // One read: a one-cycle strobe, then a bounded wait for the answer.
  // The released address is inverted so a stale value never decodes.
  task automatic read(input logic [15:0] addr, output logic [7:0] data,
                      output logic ok);
    ok   = 1'b0;
    data = 8'h00;
    @(posedge clock);
    rd_strobe <= 1'b1;
    rd_addr   <= addr;
    @(posedge clock);
    rd_strobe <= 1'b0;
    rd_addr   <= ~addr;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clock);
      if (rd_valid === 1'b1) begin
        data = rd_data;
        ok   = 1'b1;
      end
    end
  endtask
endmodule

// >>> tb/acsf_top_tb.sv
// Self-checking bench for the alert and clamp status flags.
// Assumes the host model drives the read port; the bench drives the rest.
`timescale 1ns/1ps
module acsf_top_tb;
  logic              clock;
  logic              srst;
  logic              conv_valid;
  logic [3:0]        conv_chan;
  logic [15:0]       conv_result;
  logic [3:0][15:0]  upper_thr;
  logic [3:0][15:0]  lower_thr;
  logic [3:0][15:0]  hyst_val;
  logic [3:0]        detect_en;
  logic [7:0]        setup_byte;
  logic [7:0]        clamp_pin;
  logic              rd_strobe;
  logic [15:0]       rd_addr;
  logic [7:0]        rd_data;
  logic              rd_valid;
  logic [7:0]        alert_q;
  logic [7:0]        clamp_q;
  logic [7:0]        exp_v;
  int                n_errors = 0;
  int                samples_checked = 0;

  acsf_top i_acsf_top (.clock(clock), .srst(srst), .conv_valid(conv_valid),
    .conv_chan(conv_chan), .conv_result(conv_result),
    .upper_thr(upper_thr), .lower_thr(lower_thr), .hyst_val(hyst_val),
    .detect_en(detect_en), .setup_byte(setup_byte), .clamp_pin(clamp_pin),
    .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .alert_flags_upper_channels(alert_q),
    .clamp_flags_low_channels(clamp_q));

  acsf_host_model i_acsf_host_model (.clock(clock), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_strobe(rd_strobe), .rd_addr(rd_addr));

  // Free-running 40 MHz clock.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Compare one byte and count the outcome.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Read through the host model; a missing answer ends the run.
  task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_acsf_host_model.read(addr, d, ok);
    if (!ok) begin
      n_errors++;
      summarize();
    end else begin
      check(d, exp);
    end
  endtask

  // One conversion pulse; returns once the flags have had their edge.
  task automatic conv(input logic [3:0] ch, input logic [15:0] val);
    @(posedge clock);
    conv_valid  <= 1'b1;
    conv_chan   <= ch;
    conv_result <= val;
    @(posedge clock);
    conv_valid <= 1'b0;
    #1;
  endtask

  // Change detection enables and the setup byte on a clock edge.
  task automatic setcfg(input logic [3:0] en, input logic [7:0] mode);
    @(posedge clock);
    detect_en  <= en;
    setup_byte <= mode;
  endtask

  // Main sequence; thresholds are the same on every channel.
  initial begin
    srst        = 1'b1;
    conv_valid  = 1'b0;
    conv_chan   = 4'h0;
    conv_result = 16'h0000;
    upper_thr   = {4{16'h8000}};
    lower_thr   = {4{16'h1000}};
    hyst_val    = {4{16'h0100}};
    detect_en   = 4'hf;
    setup_byte  = 8'h00;
    clamp_pin   = 8'h00;
    exp_v       = 8'h00;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    check(alert_q, 8'h00);
    check(clamp_q, 8'h00);
    rd(16'h0018, 8'h00);
    rd(16'h001a, 8'h00);
    // exact thresholds, bit pairs per channel.
    for (int k = 0; k < 4; k++) begin
      conv(4'(12 + k), 16'h8000);
      exp_v = exp_v | (8'h01 << (2 * k));
      check(alert_q, exp_v);
      conv(4'(12 + k), 16'h1000);
      exp_v = exp_v | (8'h02 << (2 * k));
      check(alert_q, exp_v);
    end
    rd(16'h0018, 8'hff);
    check(alert_q, 8'h00);
    rd(16'h0018, 8'h00);
    setcfg(4'he, 8'h00);
    conv(4'hc, 16'hffff);
    conv(4'hc, 16'h0000);
    check(alert_q, 8'h00);
    // set during a clearing read survives.
    setcfg(4'hf, 8'h00);
    fork
      conv(4'hc, 16'h8000);
      rd(16'h0018, 8'h00);
    join
    #1;
    check(alert_q, 8'h01);
    rd(16'h0018, 8'h01);
    setcfg(4'hf, 8'h80);
    conv(4'hd, 16'h8000);
    conv(4'hd, 16'h7f00);
    check(alert_q, 8'h04);
    conv(4'hd, 16'h7eff);
    check(alert_q, 8'h00);
    conv(4'hd, 16'h1000);
    conv(4'hd, 16'h1100);
    check(alert_q, 8'h08);
    conv(4'hd, 16'h1101);
    check(alert_q, 8'h00);
    // other setup bits leave hysteresis off.
    setcfg(4'hf, 8'h7f);
    conv(4'hd, 16'h8000);
    conv(4'hd, 16'h4000);
    check(alert_q, 8'h04);
    rd(16'h0018, 8'h04);
    // walking clamp bit through the synchroniser.
    for (int x = 0; x < 8; x++) begin
      @(posedge clock);
      clamp_pin <= 8'h01 << x;
      repeat (4) @(posedge clock);
      #1;
      check(clamp_q, 8'h01 << x);
    end
    rd(16'h001a, 8'h80);
    @(posedge clock);
    clamp_pin <= 8'h00;
    repeat (4) @(posedge clock);
    #1;
    check(clamp_q, 8'h00);
    rd(16'h001a, 8'h00);
    rd(16'h0019, 8'h00);
    conv(4'hf, 16'h0000);
    check(alert_q, 8'h80);
    @(posedge clock);
    clamp_pin <= 8'h5a;
    srst      <= 1'b1;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    check(alert_q, 8'h00);
    check(clamp_q, 8'h00);
    repeat (3) @(posedge clock);
    #1;
    check(clamp_q, 8'h5a);
    rd(16'h0018, 8'h00);
    summarize();
  end
endmodule
